// file: common/rda_consts.vh
// Purpose: Shared constants for the 1:1 redundancy arbiter
// Assumes: 100 MHz sys_clk, APB slave with 32-bit words
// Notes: Offsets are byte addresses
`ifndef RDA_CONSTS_VH
`define RDA_CONSTS_VH

// Register byte offsets
`define RDA_OFF_CTRL 12'h000
`define RDA_OFF_DELAY 12'h004
`define RDA_OFF_HOLD 12'h008
`define RDA_OFF_STATUS 12'h00C
`define RDA_OFF_TRIAL 12'h010

// Control field positions
`define RDA_CTRL_ROLE 0
`define RDA_CTRL_REDEN 1
`define RDA_CTRL_PREF_LO 2
`define RDA_CTRL_PREF_HI 3
`define RDA_CTRL_IFEN 4
`define RDA_CTRL_RELSEL 5
`define RDA_CTRL_ACREN 6
`define RDA_CTRL_TRIALEN 7
`define RDA_CTRL_CFGREQ 8
`define RDA_CTRL_W 9

// Reset values
`define RDA_CTRL_RST 9'h000
`define RDA_DELAY_RST 32'h0000_0100
`define RDA_HOLD_RST 32'h0000_0200

// Preference encodings
`define RDA_PREF_PRIMARY 2'h0
`define RDA_PREF_BACKUP 2'h1
`define RDA_PREF_AUTO 2'h2

// Partner silence limit in cycles
`define RDA_PEER_TIMEOUT 32'h0000_1000

// Trial budget: 1000 hours
`define RDA_TRIAL_HOURS 1000
`define RDA_CLK_MHZ 100
`define RDA_TRIAL_CYCLES (64'd1000 * 64'd3600 * 64'd100 * 64'd1000000)

`endif

// file: src/rda_timer.v
// Purpose: Restartable down-counter that flags expiry
// Assumes: Same clock as the arbiter
// Notes: Restart loads the limit; done holds until restart
module rda_timer (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// Control
	input wire restart,
	input wire run,
	input wire [31:0] limit,
	// Status
	output wire done
);
	reg [31:0] count_reg; // Remaining ticks

	// Load on restart, count down while running
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= 32'h0000_0000;
		end else if (restart) begin
			count_reg <= limit;
		end else if (run && count_reg != 32'h0000_0000) begin
			count_reg <= count_reg - 32'h0000_0001;
		end
	end

	assign done = (count_reg == 32'h0000_0000) && !restart;
endmodule // rda_timer

// file: src/rda_arbiter.v
// Purpose: Decide which modem of a 1:1 pair is online and gate its outputs
// Assumes: Peer status and alarm inputs are asynchronous pins
// Notes: Registers reached over APB; no interrupts
//
// The placing of the registers and the APB interface to the registers were decided locally.
`include "rda_consts.vh"

// Contract
// - Stand-alone enables outputs at once
// - Stand-alone transmit follows IF enable, no alarm
// - Stand-alone interface never alarm-gated
// - Stand-alone sends no partner status
// - Disabled 1:1 keeps interface muted
// - Disabled 1:1 still exchanges status
// - Silent partner means partner failed; go online
// - Primary rejects configuration from backup
// - Primary sends config only on backup request
// - Backup config overwritten by primary transfer
// - Backup stays online only while less severe
// - Worse backup returns duty after delay
// - Primary cleared: backup holds, then returns
// - Equal faults: primary is online
// - Auto: config flows from online unit
// - Auto failover sticky, switch on worse fault
// - Auto equal faults: online keeps duty
// - Auto config recovery off in redundancy
// - Trial counts down only transmitting and locked
// - Never-online backup never starts trial
// - Offline unit keeps transmit off
// - Switch request from selected relay A/B
module rda_arbiter (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Local alarm pins
	input wire [7:0] alarmIn,
	input wire relayA,
	input wire relayB,
	input wire inhibitAlarm,
	input wire carrierLock,
	input wire rxCarrierLost,
	// Partner status channel
	input wire peerValid,
	input wire [3:0] peerSeverity,
	input wire peerOnline,
	input wire peerIsBackup,
	input wire peerSwitchReq,
	input wire peerCfgReq,
	input wire peerCfgPush,
	output reg statusValid,
	output reg [3:0] statusSeverity,
	output reg statusOnline,
	output reg statusIsBackup,
	output reg switchReq,
	output reg cfgReqOut,
	// Configuration transfer control
	output reg cfgSend,
	output reg cfgAccept,
	// Output gating
	output reg txEnable,
	output reg ifaceEnable,
	output reg acrEnable,
	output reg trialExpired
);
	// Synchroniser stages for pin inputs
	reg [17:0] sync1Reg;
	reg [17:0] sync2Reg;
	wire [17:0] pinIn;
	assign pinIn = {alarmIn, relayA, relayB, inhibitAlarm, carrierLock, rxCarrierLost,
		peerValid, peerOnline, peerIsBackup, peerSwitchReq, peerCfgReq};
	reg [3:0] peerSev1Reg;
	reg [3:0] peerSev2Reg;
	reg peerPush1Reg;
	reg peerPush2Reg;
	reg [3:0] peerSev3Reg; // Third stage, compared with the second
	reg [3:0] peerSevHeldReg; // Partner rank seen steady for two cycles

	// Two-flop synchronisers; first stage feeds only the second
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1Reg <= 18'h00000;
			sync2Reg <= 18'h00000;
			peerSev1Reg <= 4'h0;
			peerSev2Reg <= 4'h0;
			peerSev3Reg <= 4'h0;
			peerSevHeldReg <= 4'h0;
			peerPush1Reg <= 1'b0;
			peerPush2Reg <= 1'b0;
		end else begin
			sync1Reg <= pinIn;
			sync2Reg <= sync1Reg;
			peerSev1Reg <= peerSeverity;
			peerSev2Reg <= peerSev1Reg;
			peerSev3Reg <= peerSev2Reg;
			// Take the rank only when all bits agree, so skew never shows a false rank
			if (peerSev2Reg == peerSev3Reg) begin
				peerSevHeldReg <= peerSev2Reg;
			end
			peerPush1Reg <= peerCfgPush;
			peerPush2Reg <= peerPush1Reg;
		end
	end

	// Synchronised views
	wire [7:0] sAlarm = sync2Reg[17:10];
	wire sRelayA = sync2Reg[9];
	wire sRelayB = sync2Reg[8];
	wire sInhibit = sync2Reg[7];
	wire sLock = sync2Reg[6];
	wire sRxLost = sync2Reg[5];
	wire sPeerValid = sync2Reg[4];
	wire sPeerOnline = sync2Reg[3];
	wire sPeerBackup = sync2Reg[2];
	wire sPeerSwReq = sync2Reg[1];
	wire sPeerCfgReq = sync2Reg[0];

	// Software registers
	reg [`RDA_CTRL_W-1:0] ctrlReg;
	reg [31:0] delayReg;
	reg [31:0] holdReg;
	wire roleOneToOne = ctrlReg[`RDA_CTRL_ROLE];
	wire redEnable = ctrlReg[`RDA_CTRL_REDEN];
	wire [1:0] pref = ctrlReg[`RDA_CTRL_PREF_HI:`RDA_CTRL_PREF_LO];
	wire ifOutEnable = ctrlReg[`RDA_CTRL_IFEN];
	wire relaySel = ctrlReg[`RDA_CTRL_RELSEL];
	wire acrUser = ctrlReg[`RDA_CTRL_ACREN];
	wire trialOn = ctrlReg[`RDA_CTRL_TRIALEN];
	wire cfgReqUser = ctrlReg[`RDA_CTRL_CFGREQ];

	// APB decode: zero-wait, always ready
	wire apbWrite = psel && penable && pwrite;
	assign pready = 1'b1;
	wire addrHit = (paddr == `RDA_OFF_CTRL) || (paddr == `RDA_OFF_DELAY) ||
		(paddr == `RDA_OFF_HOLD) || (paddr == `RDA_OFF_STATUS) || (paddr == `RDA_OFF_TRIAL);
	assign pslverr = psel && penable && !addrHit;

	// Register writes; config request bit self-clears after one cycle
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlReg <= `RDA_CTRL_RST;
			delayReg <= `RDA_DELAY_RST;
			holdReg <= `RDA_HOLD_RST;
		end else begin
			ctrlReg[`RDA_CTRL_CFGREQ] <= 1'b0;
			if (apbWrite) begin
				case (paddr)
					`RDA_OFF_CTRL: begin
						ctrlReg <= pwdata[`RDA_CTRL_W-1:0];
					end
					`RDA_OFF_DELAY: begin
						delayReg <= pwdata;
					end
					`RDA_OFF_HOLD: begin
						holdReg <= pwdata;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Local severity: count of active alarms
	reg [3:0] localSev;
	integer i;
	always @* begin
		localSev = 4'h0;
		for (i = 0; i < 8; i = i + 1) begin
			localSev = localSev + {3'h0, sAlarm[i]};
		end
	end

	// Partner silence watchdog
	reg [31:0] silentReg;
	wire peerLost = (silentReg >= `RDA_PEER_TIMEOUT);
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			silentReg <= 32'h0000_0000;
		end else if (sPeerValid) begin
			silentReg <= 32'h0000_0000;
		end else if (!peerLost) begin
			silentReg <= silentReg + 32'h0000_0001;
		end
	end

	// Severity comparisons; lost partner ranks worst
	wire [3:0] peerSev = peerLost ? 4'hF : peerSevHeldReg;
	wire localWorse = localSev > peerSev;
	wire localBetter = localSev < peerSev;
	reg [3:0] prevLocalReg;
	reg [3:0] prevPeerReg;
	wire sevChange = (prevLocalReg != localSev) || (prevPeerReg != peerSev);

	// Arbiter states
	localparam ST_OFF = 4'b0001; // Offline
	localparam ST_ON = 4'b0010; // Online, settled
	localparam ST_DELAY = 4'b0100; // Online, waiting delay to hand back
	localparam ST_HOLD = 4'b1000; // Online, waiting hold to hand back
	reg [3:0] state_reg;
	reg [3:0] state_next;

	// Timers for switch delay and hold
	wire delayDone;
	wire holdDone;
	wire delayRestart = sevChange || (state_reg != ST_DELAY);
	wire holdRestart = sevChange || (state_reg != ST_HOLD);
	rda_timer uDelay (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.restart(delayRestart),
		.run(1'b1),
		.limit(delayReg),
		.done(delayDone)
	);
	rda_timer uHold (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.restart(holdRestart),
		.run(1'b1),
		.limit(holdReg),
		.done(holdDone)
	);

	// Next-state arbitration in 1:1 role
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: begin
				if (peerLost) begin
					state_next = ST_ON;
				end else if (pref == `RDA_PREF_PRIMARY) begin
					if (!localWorse) begin
						state_next = ST_ON;
					end
				end else if (localBetter) begin
					state_next = ST_ON;
				end else if (!sPeerOnline && !localWorse && pref == `RDA_PREF_AUTO) begin
					state_next = ST_ON;
				end
			end
			ST_ON: begin
				if (pref == `RDA_PREF_PRIMARY) begin
					if (localWorse) begin
						state_next = ST_OFF;
					end
				end else if (localWorse) begin
					state_next = ST_DELAY;
				end else if (pref == `RDA_PREF_BACKUP && !localBetter) begin
					state_next = ST_HOLD;
				end
			end
			ST_DELAY: begin
				if (peerLost || !localWorse) begin
					state_next = ST_ON;
				end else if (delayDone) begin
					state_next = ST_OFF;
				end
			end
			ST_HOLD: begin
				if (peerLost || localBetter) begin
					state_next = ST_ON;
				end else if (localWorse) begin
					state_next = ST_DELAY;
				end else if (holdDone) begin
					state_next = ST_OFF;
				end
			end
			default: begin
				state_next = ST_OFF;
			end
		endcase
		if (!roleOneToOne || !redEnable) begin
			state_next = ST_OFF;
		end
	end

	// State and severity history
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_OFF;
			prevLocalReg <= 4'h0;
			prevPeerReg <= 4'h0;
		end else begin
			state_reg <= state_next;
			prevLocalReg <= localSev;
			prevPeerReg <= peerSev;
		end
	end

	wire online = (state_reg != ST_OFF);

	// Output gating and partner status
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txEnable <= 1'b0;
			ifaceEnable <= 1'b0;
			statusValid <= 1'b0;
			statusSeverity <= 4'h0;
			statusOnline <= 1'b0;
			statusIsBackup <= 1'b0;
			switchReq <= 1'b0;
			acrEnable <= 1'b0;
		end else if (!roleOneToOne) begin
			ifaceEnable <= 1'b1;
			txEnable <= ifOutEnable && !sInhibit;
			statusValid <= 1'b0;
			statusSeverity <= 4'h0;
			statusOnline <= 1'b0;
			statusIsBackup <= 1'b0;
			switchReq <= 1'b0;
			acrEnable <= acrUser;
		end else begin
			ifaceEnable <= redEnable && online;
			txEnable <= redEnable && online && ifOutEnable && !sInhibit;
			statusValid <= 1'b1;
			statusSeverity <= localSev;
			statusOnline <= online;
			statusIsBackup <= (pref == `RDA_PREF_BACKUP);
			switchReq <= relaySel ? sRelayB : sRelayA;
			acrEnable <= 1'b0;
		end
	end

	// Configuration transfer direction
	wire pushFromBackup = peerPush2Reg && sPeerBackup;
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfgSend <= 1'b0;
			cfgAccept <= 1'b0;
			cfgReqOut <= 1'b0;
		end else if (!roleOneToOne) begin
			cfgSend <= 1'b0;
			cfgAccept <= 1'b0;
			cfgReqOut <= 1'b0;
		end else begin
			case (pref)
				`RDA_PREF_PRIMARY: begin
					cfgSend <= sPeerCfgReq && sPeerBackup;
					cfgAccept <= peerPush2Reg && !pushFromBackup;
					cfgReqOut <= 1'b0;
				end
				`RDA_PREF_BACKUP: begin
					cfgSend <= 1'b0;
					cfgAccept <= peerPush2Reg && !sPeerBackup;
					cfgReqOut <= cfgReqUser;
				end
				default: begin
					cfgSend <= online && sPeerCfgReq;
					cfgAccept <= !online && peerPush2Reg;
					cfgReqOut <= !online && cfgReqUser;
				end
			endcase
		end
	end

	// Trial countdown
	reg [63:0] trialReg;
	reg everOnlineReg;
	wire trialRun = trialOn && txEnable && sLock && !trialExpired;
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			trialReg <= 64'h0000_0000_0000_0000;
			everOnlineReg <= 1'b0;
			trialExpired <= 1'b0;
		end else begin
			// Only real online duty counts; stand-alone is handled below
			if (online) begin
				everOnlineReg <= 1'b1;
			end
			if (!trialOn) begin
				trialReg <= `RDA_TRIAL_CYCLES;
				trialExpired <= 1'b0;
			end else if (trialRun &&
				(everOnlineReg || !roleOneToOne || pref != `RDA_PREF_BACKUP)) begin
				trialReg <= trialReg - 64'h0000_0000_0000_0001;
				trialExpired <= (trialReg == 64'h0000_0000_0000_0001);
			end
		end
	end

	// APB read mux
	always @* begin
		prdata = 32'h0000_0000;
		case (paddr)
			`RDA_OFF_CTRL: prdata = {23'h000000, ctrlReg};
			`RDA_OFF_DELAY: prdata = delayReg;
			`RDA_OFF_HOLD: prdata = holdReg;
			`RDA_OFF_STATUS: prdata = {16'h0000, 2'h0, sPeerSwReq, sRxLost, peerLost, trialExpired,
				everOnlineReg, online, localSev, state_reg};
			`RDA_OFF_TRIAL: prdata = trialReg[63:32] == 32'h0 ? trialReg[31:0] : 32'hFFFF_FFFF;
			default: prdata = 32'h0000_0000;
		endcase
	end
endmodule // rda_arbiter

// file: test/rda_arbiter_monitor.sv
// Purpose: Port assertions for the redundancy arbiter
// Assumes: One sys_clk domain, async high reset
// Notes: CTRL is shadowed from APB writes
`include "rda_consts.vh"
module rda_arbiter_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Pins and partner
	input wire logic inhibitAlarm,
	input wire logic peerValid,
	input wire logic peerIsBackup,
	input wire logic peerCfgReq,
	// Outputs
	input wire logic statusValid,
	input wire logic statusOnline,
	input wire logic cfgReqOut,
	input wire logic cfgSend,
	input wire logic cfgAccept,
	input wire logic txEnable,
	input wire logic ifaceEnable,
	input wire logic acrEnable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] ctrl_reg; // Last CTRL write
	logic [3:0] age_reg; // Cycles since it, stops at six
	logic [3:0] req_reg; // Cycles since partner request
	logic [12:0] lost_reg; // Cycles of partner silence
	wire settled = age_reg > 4'h5; // CTRL effect has landed
	wire pair = settled && ctrl_reg[1:0] == 2'h3; // Redundant and enabled
	wire primPair = pair && ctrl_reg[3:2] == `RDA_PREF_PRIMARY; // Primary of a live pair
	wire soloTx = settled && ctrl_reg[4:0] == 5'h10; // Stand-alone, IF output on
	wire quiet = statusValid && !statusOnline; // Reported offline to partner
	// Shadow register and counters
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= 9'h000;
			age_reg <= 4'h0;
			req_reg <= 4'hF;
			lost_reg <= 13'h0000;
		end else begin
			if (psel && penable && pwrite && paddr == `RDA_OFF_CTRL) begin
				ctrl_reg <= pwdata[8:0];
				age_reg <= 4'h0;
			end else if (!settled) begin
				age_reg <= age_reg + 4'h1;
			end
			req_reg <= peerCfgReq ? 4'h0 : (req_reg == 4'hF ? req_reg : req_reg + 4'h1);
			lost_reg <= peerValid ? 13'h0000 : (lost_reg == 13'h1020 ? lost_reg : lost_reg + 13'h0001);
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_solo_outputs_on: assert property (settled && !ctrl_reg[0] |-> ifaceEnable && !statusValid)
		else $error("stand-alone outputs wrong");
	chk_solo_tx_on: assert property ((!inhibitAlarm)[*5] ##0 soloTx |-> txEnable)
		else $error("stand-alone transmit off");
	chk_inhibit_tx: assert property (inhibitAlarm[*5] |-> !txEnable)
		else $error("transmit despite inhibit");
	chk_disabled_muted: assert property (settled && ctrl_reg[1:0] == 2'h1 |-> !ifaceEnable && statusValid)
		else $error("disabled unit not muted");
	chk_offline_quiet: assert property (quiet && $past(quiet) |-> !txEnable)
		else $error("offline unit transmits");
	chk_cfgreq_pulse: assert property (cfgReqOut |=> !cfgReqOut)
		else $error("update request too long");
	chk_send_on_req: assert property ($rose(cfgSend) |-> req_reg < 4'h8)
		else $error("config sent unasked");
	chk_primary_reject: assert property (peerIsBackup[*4] ##0 primPair |-> !cfgAccept)
		else $error("primary accepts config");
	chk_lost_online: assert property (pair && lost_reg == 13'h1020 |-> statusOnline)
		else $error("silent partner, still offline");
	chk_acr_off: assert property (pair |-> !acrEnable)
		else $error("recovery on in redundancy");
	cover property (statusValid && statusOnline);
	cover property ($rose(cfgSend));
	cover property (lost_reg == 13'h1020 && statusOnline);
endmodule // rda_arbiter_monitor
bind rda_arbiter rda_arbiter_monitor u_mon (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .inhibitAlarm, .peerValid, .peerIsBackup, .peerCfgReq, .statusValid, .statusOnline,
	.cfgReqOut, .cfgSend, .cfgAccept, .txEnable, .ifaceEnable, .acrEnable);

// file: test/rda_peer_model.sv
// Purpose: Partner modem on the status channel
// Assumes: Knobs set by the bench
// Notes: Silent partner toggles its dead lines
module rda_peer_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Knobs
	input wire logic present,
	input wire logic [3:0] sev,
	input wire logic isBack,
	input wire logic wantCfg,
	// Arbiter side
	input wire logic statusOnline,
	input wire logic cfgReqOut,
	// Channel
	output logic peerValid,
	output logic [3:0] peerSeverity,
	output logic peerOnline,
	output logic peerIsBackup,
	output logic peerSwitchReq,
	output logic peerCfgReq,
	output logic peerCfgPush
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] push_reg; // Push cycles left
	// Status out, push only on request
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{peerValid, peerSeverity, peerOnline, peerIsBackup} <= 7'h00;
			{peerSwitchReq, peerCfgReq, peerCfgPush, push_reg} <= 7'h00;
		end else if (present) begin
			peerValid <= 1'b1;
			peerSeverity <= sev;
			peerOnline <= !statusOnline;
			peerIsBackup <= isBack;
			peerSwitchReq <= sev != 4'h0;
			peerCfgReq <= wantCfg && isBack;
			push_reg <= (cfgReqOut && !isBack) ? 4'h8 : push_reg - {3'h0, push_reg != 4'h0};
			peerCfgPush <= push_reg != 4'h0;
		end else begin
			peerValid <= 1'b0;
			{peerSeverity, peerOnline, peerIsBackup} <= ~{peerSeverity, peerOnline, peerIsBackup};
			{peerSwitchReq, peerCfgReq, peerCfgPush} <= ~{peerSwitchReq, peerCfgReq, peerCfgPush};
			push_reg <= 4'h0;
		end
	end
endmodule // rda_peer_model

// file: test/one_to_one_redundancy_arbiter_test.sv
// Purpose: Directed bench for the redundancy arbiter
// Assumes: Zero-wait APB slave, 100 MHz clock
// Notes: Partner model sits on the status channel
`include "rda_consts.vh"
module one_to_one_redundancy_arbiter_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er, seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] trialA; // Trial count snapshot
	logic [7:0] alarmIn;
	logic relayA, relayB, inhibitAlarm, carrierLock, rxCarrierLost;
	logic peerValid, peerOnline, peerIsBackup, peerSwitchReq, peerCfgReq, peerCfgPush;
	logic [3:0] peerSeverity, statusSeverity, sev;
	logic statusValid, statusOnline, statusIsBackup, switchReq, cfgReqOut, cfgSend;
	logic cfgAccept, txEnable, ifaceEnable, acrEnable, trialExpired, present, isBack, wantCfg;
	int bad_count, checked, cycles;
	rda_arbiter u_dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .alarmIn, .relayA, .relayB, .inhibitAlarm, .carrierLock,
		.rxCarrierLost, .peerValid, .peerSeverity, .peerOnline, .peerIsBackup, .peerSwitchReq,
		.peerCfgReq, .peerCfgPush, .statusValid, .statusSeverity, .statusOnline, .statusIsBackup,
		.switchReq, .cfgReqOut, .cfgSend, .cfgAccept, .txEnable, .ifaceEnable, .acrEnable,
		.trialExpired);
	rda_peer_model u_peer (.sys_clk, .sys_rst, .present, .sev, .isBack, .wantCfg, .statusOnline,
		.cfgReqOut, .peerValid, .peerSeverity, .peerOnline, .peerIsBackup, .peerSwitchReq,
		.peerCfgReq, .peerCfgPush);
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// One APB transfer, held until pready
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Word compare
	task automatic cmpW(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Bit compare
	task automatic cmpB(input logic g, input logic e);
		cmpW({31'h0, g}, {31'h0, e});
	endtask
	task automatic end_of_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 10000) begin
			bad_count++;
			end_of_test();
		end
	end
	// Main sequence
	initial begin
		{sys_rst, present} = 2'h3;
		{psel, penable, pwrite, paddr, pwdata} = 47'h0;
		{alarmIn, relayA, relayB, inhibitAlarm, carrierLock, rxCarrierLost} = 13'h0;
		{sev, isBack, wantCfg} = 6'h0;
		tick(20);
		sys_rst <= 1'b0;
		// Reset values, unmapped place
		apb(`RDA_OFF_CTRL, 1'b0, 32'h0);
		cmpW(rd, 32'h0);
		apb(`RDA_OFF_DELAY, 1'b0, 32'h0);
		cmpW(rd, `RDA_DELAY_RST);
		apb(`RDA_OFF_HOLD, 1'b0, 32'h0);
		cmpW(rd, `RDA_HOLD_RST);
		apb(12'h014, 1'b0, 32'h0);
		cmpB(er, 1'b1);
		apb(`RDA_OFF_DELAY, 1'b1, 32'h20);
		apb(`RDA_OFF_HOLD, 1'b1, 32'h20);
		apb(`RDA_OFF_DELAY, 1'b0, 32'h0);
		cmpW(rd, 32'h20);
		// Backup, partner primary healthy
		carrierLock <= 1'b1;
		apb(`RDA_OFF_CTRL, 1'b1, 32'h97);
		tick(10);
		cmpB(statusOnline, 1'b0);
		cmpB(txEnable, 1'b0);
		cmpB(statusIsBackup, 1'b1);
		apb(`RDA_OFF_STATUS, 1'b0, 32'h0);
		cmpB(rd[9], 1'b0);
		apb(`RDA_OFF_TRIAL, 1'b0, 32'h0);
		cmpW(rd, 32'hFFFF_FFFF);
		trialA = u_dut.trialReg;
		tick(30);
		cmpB(u_dut.trialReg == trialA, 1'b1);
		// Primary fails, backup worse, recovery
		sev <= 4'h3;
		tick(20);
		cmpB(statusOnline, 1'b1);
		apb(`RDA_OFF_STATUS, 1'b0, 32'h0);
		cmpB(rd[13], 1'b1);
		alarmIn <= 8'h0F;
		tick(10);
		cmpB(statusOnline, 1'b1);
		cmpW({28'h0, statusSeverity}, 32'h4);
		tick(50);
		cmpB(statusOnline, 1'b0);
		alarmIn <= 8'h00;
		tick(20);
		cmpB(statusOnline, 1'b1);
		sev <= 4'h0;
		tick(10);
		cmpB(statusOnline, 1'b1);
		tick(50);
		cmpB(statusOnline, 1'b0);
		// Update request, primary pushes
		apb(`RDA_OFF_CTRL, 1'b1, 32'h117);
		seen = 1'b0;
		repeat (30) begin
			@(posedge sys_clk);
			seen |= cfgAccept;
		end
		cmpB(seen, 1'b1);
		// Partner falls silent
		present <= 1'b0;
		tick(4200);
		cmpB(statusOnline, 1'b1);
		apb(`RDA_OFF_STATUS, 1'b0, 32'h0);
		cmpB(rd[11], 1'b1);
		present <= 1'b1;
		// Stand-alone, recovery left to the user
		apb(`RDA_OFF_CTRL, 1'b1, 32'h50);
		tick(8);
		cmpB(ifaceEnable, 1'b1);
		cmpB(acrEnable, 1'b1);
		cmpB(txEnable, 1'b1);
		cmpB(statusValid, 1'b0);
		alarmIn <= 8'hFF;
		inhibitAlarm <= 1'b1;
		tick(8);
		cmpB(ifaceEnable, 1'b1);
		cmpB(txEnable, 1'b0);
		alarmIn <= 8'h00;
		inhibitAlarm <= 1'b0;
		// Disabled pair member
		isBack <= 1'b1;
		apb(`RDA_OFF_CTRL, 1'b1, 32'h11);
		tick(8);
		cmpB(ifaceEnable, 1'b0);
		cmpB(statusValid, 1'b1);
		// Primary against backup partner
		relayA <= 1'b1;
		apb(`RDA_OFF_CTRL, 1'b1, 32'hD3);
		tick(8);
		cmpB(statusOnline, 1'b1);
		cmpB(acrEnable, 1'b0);
		cmpB(switchReq, 1'b1);
		rxCarrierLost <= 1'b1;
		trialA = u_dut.trialReg;
		tick(20);
		cmpW(trialA[31:0] - u_dut.trialReg[31:0], 32'h14);
		cmpB(trialExpired, 1'b0);
		apb(`RDA_OFF_STATUS, 1'b0, 32'h0);
		cmpB(rd[12], 1'b1);
		cmpB(acrEnable, 1'b0);
		rxCarrierLost <= 1'b0;
		carrierLock <= 1'b0;
		tick(4);
		trialA = u_dut.trialReg;
		tick(10);
		cmpB(u_dut.trialReg == trialA, 1'b1);
		carrierLock <= 1'b1;
		wantCfg <= 1'b1;
		seen = 1'b0;
		repeat (20) begin
			@(posedge sys_clk);
			seen |= cfgSend;
		end
		cmpB(seen, 1'b1);
		wantCfg <= 1'b0;
		apb(`RDA_OFF_CTRL, 1'b1, 32'hF3);
		tick(8);
		cmpB(switchReq, 1'b0);
		// Auto, sticky duty
		isBack <= 1'b0;
		apb(`RDA_OFF_CTRL, 1'b1, 32'h1B);
		tick(100);
		cmpB(statusOnline, 1'b1);
		alarmIn <= 8'h07;
		tick(100);
		cmpB(statusOnline, 1'b0);
		alarmIn <= 8'h00;
		tick(100);
		cmpB(statusOnline, 1'b0);
		end_of_test();
	end
endmodule // one_to_one_redundancy_arbiter_test
